// ==== hdl/cbe_regs.sv ====
// balancing expiry register bank for cells one to five, with elapsed timer
// assumes an AHB-Lite master on hclk; switch enables live elsewhere
//
// Summary of operation
// - master expiry governs group, discharge and manual modes
// - master expiry writes ignored unless mode is off
// - cell two-five writes ignored in automatic modes
// - per-cell expiry used only in individual automatic mode
// - all-ones expiry never expires
// - zero expiry means already expired, balancing off
// - ten-bit expiry, unit chosen by mode
// - in individual mode each cell register times its own switch
// - manual restart zeroes timer, ignored once expired
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
module cbe_regs import cbe_pkg::*; #(
    parameter int CYC_SEC = CYC_PER_SEC
) (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic hreadyout, // slave ready out
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    output logic [NUM_CELLS-1:0] cell_balance_allow, // switch may conduct
    output logic [EXP_W-1:0] balancing_elapsed_timer // elapsed units
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic expiry_hit(input logic [9:0] lim, input logic [9:0] t);
        expiry_hit = (lim == EXP_RESET) || (lim != EXP_UNLIMITED && t >= lim);
    endfunction

    function automatic logic idx_mapped(input logic [7:0] idx);
        idx_mapped = (idx >= IDX_EXP_MASTER && idx <= IDX_EXP_CELL_FIVE)
            || idx == IDX_BAL_CTRL || idx == IDX_BAL_STATUS;
    endfunction

    // ---------------------------------------------------------------
    // bus address phase capture
    // ---------------------------------------------------------------
    logic dp_wr_r;
    logic dp_rd_r;
    logic rd_wait_r;
    logic [7:0] dp_idx_r;
    logic ap_take;
    logic [9:0] exp_r [NUM_CELLS];
    logic [2:0] mode_r;
    logic [9:0] timer_r;
    logic [NUM_CELLS-1:0] allow_r;
    logic [31:0] rdata_r;
    logic [9:0] lim [NUM_CELLS];
    logic [NUM_CELLS-1:0] hit;
    logic indiv;
    logic wr_ctrl;
    logic restart_req;
    logic restart_ok;
    logic unit_tick;
    logic sec_tick;
    logic min_tick;
    logic hour_tick;

    // reads take one wait state so a write just before is seen
    assign ap_take = hsel && htrans[1] && hready;
    assign hreadyout = !(dp_rd_r && rd_wait_r);
    assign hresp = 1'b0;
    assign hrdata = rdata_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r <= 1'b0;
            dp_rd_r <= 1'b0;
            dp_idx_r <= 8'h00;
        end else if (hreadyout) begin
            dp_wr_r <= ap_take && hwrite;
            dp_rd_r <= ap_take && !hwrite;
            if (ap_take) begin
                dp_idx_r <= haddr[9:2];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_wait_r <= 1'b0;
        end else if (hreadyout) begin
            rd_wait_r <= ap_take && !hwrite;
        end else begin
            rd_wait_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // expiry registers
    // ---------------------------------------------------------------
    for (genvar k = 0; k < NUM_CELLS; k++) begin : g_exp
        logic wr_hit;
        logic locked;
        assign wr_hit = dp_wr_r && dp_idx_r == IDX_EXP_MASTER + 8'(k);
        // master locks in any mode but off, cells only in automatic ones
        assign locked = (k == 0) ? (mode_r != CBE_OFF) : mode_r[2];
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                exp_r[k] <= EXP_RESET;
            end else if (wr_hit && !locked) begin
                exp_r[k] <= hwdata[EXP_W-1:0];
            end
        end
        // own register only in individual mode, else the master
        assign lim[k] = (indiv && k != 0) ? exp_r[k] : exp_r[0];
        assign hit[k] = expiry_hit(lim[k], timer_r);
    end

    // ---------------------------------------------------------------
    // mode control and restart strobe
    // ---------------------------------------------------------------
    assign indiv = mode_r == CBE_INDIV_SEC || mode_r == CBE_INDIV_MIN;
    assign wr_ctrl = dp_wr_r && dp_idx_r == IDX_BAL_CTRL;
    assign restart_req = wr_ctrl && hwdata[CTRL_RESTART_BIT];
    // restart applies in manual mode and only before the watchdog expires
    assign restart_ok = restart_req && mode_r == CBE_MANUAL_SEC
        && hwdata[CTRL_MODE_LSB +: 3] == mode_r && !hit[0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r <= CBE_OFF;
        end else if (wr_ctrl) begin
            mode_r <= hwdata[CTRL_MODE_LSB +: 3];
        end
    end

    // ---------------------------------------------------------------
    // elapsed timer
    // ---------------------------------------------------------------
    cbe_timebase #(
        .CYC_SEC(CYC_SEC)
    ) u_tb (
        .hclk(hclk),
        .hresetn(hresetn),
        .clr(wr_ctrl),
        .sec_tick(sec_tick),
        .min_tick(min_tick),
        .hour_tick(hour_tick)
    );

    always_comb begin
        unique case (mode_r)
            CBE_OFF: unit_tick = 1'b0;
            CBE_MANUAL_SEC, CBE_INDIV_SEC, CBE_GROUP_SEC: unit_tick = sec_tick;
            CBE_DISCH_MIN, CBE_INDIV_MIN, CBE_GROUP_MIN: unit_tick = min_tick;
            CBE_DISCH_HOUR: unit_tick = hour_tick;
        endcase
    end

    // a control write starts a fresh balancing period unless it sets a refused restart; timer saturates
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_r <= 10'h000;
        end else if (restart_ok || (wr_ctrl && !restart_req)) begin
            timer_r <= 10'h000;
        end else if (wr_ctrl) begin
            timer_r <= timer_r;
        end else if (unit_tick && timer_r != EXP_UNLIMITED) begin
            timer_r <= timer_r + 10'h001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            allow_r <= '0;
        end else begin
            for (int k = 0; k < NUM_CELLS; k++) begin
                // in manual mode the master acts as a watchdog on all cells
                allow_r[k] <= mode_r != CBE_OFF && !hit[k]
                    && !(mode_r == CBE_MANUAL_SEC && hit[0]);
            end
        end
    end

    assign cell_balance_allow = allow_r;
    assign balancing_elapsed_timer = timer_r;

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= 32'h0000_0000;
        end else if (dp_rd_r && rd_wait_r) begin
            rdata_r <= 32'h0000_0000;
            if (dp_idx_r >= IDX_EXP_MASTER && dp_idx_r <= IDX_EXP_CELL_FIVE) begin
                rdata_r[EXP_W-1:0] <= exp_r[3'(dp_idx_r - IDX_EXP_MASTER)];
            end else if (dp_idx_r == IDX_BAL_CTRL) begin
                rdata_r[CTRL_MODE_LSB +: 3] <= mode_r;
            end else if (dp_idx_r == IDX_BAL_STATUS) begin
                rdata_r[STAT_TIMER_LSB +: EXP_W] <= timer_r;
                rdata_r[STAT_ALLOW_LSB +: NUM_CELLS] <= allow_r;
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_master_lock: assert property (@(posedge hclk) disable iff (!hresetn)
        (dp_wr_r && dp_idx_r == IDX_EXP_MASTER && mode_r != CBE_OFF) |=> $stable(exp_r[0]))
        else $error("master expiry changed while balancing");

    a_cell_lock: assert property (@(posedge hclk) disable iff (!hresetn)
        (dp_wr_r && dp_idx_r == IDX_EXP_CELL_THREE && mode_r[2]) |=> $stable(exp_r[2]))
        else $error("cell expiry changed in automatic mode");

    a_cell_unused: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode_r != CBE_OFF && !indiv && exp_r[0] == EXP_UNLIMITED
            && mode_r != CBE_MANUAL_SEC) |=> allow_r == '1)
        else $error("cell expiry used outside individual mode");

    a_unlimited: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode_r != CBE_OFF && !indiv && exp_r[0] == EXP_UNLIMITED) |=> allow_r[0])
        else $error("unlimited expiry stopped balancing");

    a_zero_expired: assert property (@(posedge hclk) disable iff (!hresetn)
        (exp_r[0] == EXP_RESET) |=> !allow_r[0])
        else $error("zero expiry allowed balancing");

    a_unit_select: assert property (@(posedge hclk) disable iff (!hresetn)
        (!unit_tick && !wr_ctrl) |=> $stable(timer_r))
        else $error("timer moved without a unit tick");

    a_own_switch: assert property (@(posedge hclk) disable iff (!hresetn)
        (indiv && exp_r[3] != EXP_UNLIMITED && timer_r >= exp_r[3]) |=> !allow_r[3])
        else $error("cell four ran past its own expiry");

    a_manual_watch: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode_r == CBE_MANUAL_SEC && hit[0]) |=> allow_r == '0)
        else $error("manual watchdog expiry left a switch on");

    a_restart_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        restart_ok |=> timer_r == 10'h000 ##1 timer_r <= 10'h001)
        else $error("restart did not zero the timer");

    a_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (dp_rd_r && hreadyout && dp_idx_r <= IDX_EXP_CELL_FIVE) |-> hrdata[31:EXP_W] == '0)
        else $error("upper expiry bits read nonzero");

    a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        (ap_take && !hwrite && hreadyout) |=> !hreadyout ##1 hreadyout)
        else $error("read answer not after one wait state");

    a_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (dp_rd_r && hreadyout && !idx_mapped(dp_idx_r)) |-> hrdata == 32'h0)
        else $error("unmapped read returned data");

endmodule

// ==== hdl/cbe_pkg.sv ====
// constants, register map and mode encoding of the balancing expiry bank
// assumes a 100 MHz clock and one register per aligned 32-bit word
package cbe_pkg;

    // ---------------------------------------------------------------
    // clock and time base
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 10_000;
    localparam longint SECOND_PS = 64'd1_000_000_000_000;
    localparam int CYC_PER_SEC = int'(SECOND_PS / CLK_PERIOD_PS);
    localparam int SEC_PER_MIN = 60;
    localparam int MIN_PER_HOUR = 60;

    // ---------------------------------------------------------------
    // register indices; byte address is four times the index
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX_EXP_MASTER = 8'h70;
    localparam logic [7:0] IDX_EXP_CELL_TWO = 8'h71;
    localparam logic [7:0] IDX_EXP_CELL_THREE = 8'h72;
    localparam logic [7:0] IDX_EXP_CELL_FOUR = 8'h73;
    localparam logic [7:0] IDX_EXP_CELL_FIVE = 8'h74;
    localparam logic [7:0] IDX_BAL_CTRL = 8'h78;
    localparam logic [7:0] IDX_BAL_STATUS = 8'h79;

    // ---------------------------------------------------------------
    // fields and reset values
    // ---------------------------------------------------------------
    localparam int NUM_CELLS = 5;
    localparam int EXP_W = 10;
    localparam logic [9:0] EXP_RESET = 10'h000;
    localparam logic [9:0] EXP_UNLIMITED = 10'h3ff;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RESTART_BIT = 8;
    localparam int STAT_TIMER_LSB = 0;
    localparam int STAT_ALLOW_LSB = 16;

    typedef enum logic [2:0] {
        CBE_OFF = 3'b000,
        CBE_MANUAL_SEC = 3'b001,
        CBE_DISCH_MIN = 3'b010,
        CBE_DISCH_HOUR = 3'b011,
        CBE_INDIV_SEC = 3'b100,
        CBE_INDIV_MIN = 3'b101,
        CBE_GROUP_SEC = 3'b110,
        CBE_GROUP_MIN = 3'b111
    } cbe_mode_e;

endpackage

// ==== hdl/cbe_timebase.sv ====
// seconds, minutes and hours as one-cycle enables derived from hclk
// assumes one clock; clr restarts every prescaler in step
`timescale 1ns/1ps
module cbe_timebase import cbe_pkg::*; #(
    parameter int CYC_SEC = CYC_PER_SEC
) (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // async reset, active low
    input wire logic clr, // restart prescalers
    output logic sec_tick, // one-cycle pulse per second
    output logic min_tick, // one-cycle pulse per minute
    output logic hour_tick // one-cycle pulse per hour
);

    logic [31:0] cyc_r;
    logic [5:0] sec_r;
    logic [5:0] min_r;
    logic sec_end;

    assign sec_end = (cyc_r == 32'(CYC_SEC - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc_r <= 32'h0;
            sec_r <= 6'h0;
            min_r <= 6'h0;
        end else if (clr) begin
            cyc_r <= 32'h0;
            sec_r <= 6'h0;
            min_r <= 6'h0;
        end else if (sec_end) begin
            cyc_r <= 32'h0;
            if (sec_r == 6'(SEC_PER_MIN - 1)) begin
                sec_r <= 6'h0;
                min_r <= (min_r == 6'(MIN_PER_HOUR - 1)) ? 6'h0 : min_r + 6'h1;
            end else begin
                sec_r <= sec_r + 6'h1;
            end
        end else begin
            cyc_r <= cyc_r + 32'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sec_tick <= 1'b0;
            min_tick <= 1'b0;
            hour_tick <= 1'b0;
        end else begin
            sec_tick <= sec_end && !clr;
            min_tick <= sec_end && !clr && sec_r == 6'(SEC_PER_MIN - 1);
            hour_tick <= sec_end && !clr && sec_r == 6'(SEC_PER_MIN - 1)
                && min_r == 6'(MIN_PER_HOUR - 1);
        end
    end

endmodule

// ==== sim/cell_balance_expiry_regs_tb.sv ====
// self-checking bench for the balancing expiry register bank
// assumes cbe_regs as the only AHB-Lite slave, hready looped back from hreadyout
`timescale 1ns/1ps
`define CHK(act, exp) begin \
    checked++; \
    if ((act) !== (exp)) begin \
        num_errors++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, (act), (exp)); \
    end \
end

module cell_balance_expiry_regs_tb import cbe_pkg::*;;
    // ---------------------------------------------------------------
    // clock, reset and bus signals
    // ---------------------------------------------------------------
    localparam int TB_CYC_SEC = 10; // minute becomes 600 cycles
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [NUM_CELLS-1:0] allow;
    logic [EXP_W-1:0] timer;
    int num_errors = 0;
    int checked = 0;
    logic [9:0] exp_r [5];

    always #5 hclk = ~hclk;

    cbe_regs #(.CYC_SEC(TB_CYC_SEC)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cell_balance_allow(allow), .balancing_elapsed_timer(timer)
    );

    // ---------------------------------------------------------------
    // bus tasks; called just after a rising edge
    // ---------------------------------------------------------------
    task automatic xfer(input logic [7:0] idx, input logic wr_en, input logic [31:0] wd,
                        output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr_en;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 100) begin
            @(posedge hclk);
            n++;
        end
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 100) begin
            @(posedge hclk);
            n++;
        end
        rd = hrdata;
        // a stuck slave is counted here rather than hanging the run
        if (n >= 100) num_errors++;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        xfer(idx, 1'b1, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        xfer(idx, 1'b0, 32'h0, r);
        `CHK(r, exp)
        `CHK(hresp, 1'b0)
    endtask

    function automatic logic [7:0] exp_idx(input int i);
        return 8'(IDX_EXP_MASTER + i);
    endfunction

    task automatic finish_test();
        $display("errors=%0d checks=%0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // watchdog, well above the roughly 1250 cycles the tests need
    // ---------------------------------------------------------------
    initial begin
        repeat (30000) @(posedge hclk);
        num_errors++;
        finish_test();
    end

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 5; i++) rd_chk(exp_idx(i), 32'h0);
        `CHK(allow, 5'h00)
        // upper bits written as ones must read back as zero
        for (int i = 0; i < 5; i++) begin
            exp_r[i] = 10'h200 + 10'(i);
            wr(exp_idx(i), {22'h3fffff, exp_r[i]});
            rd_chk(exp_idx(i), {22'h0, exp_r[i]});
        end
        // every mode: master locked unless off, cells locked in automatic modes
        for (int m = 1; m < 8; m++) begin
            wr(IDX_BAL_CTRL, 32'(m));
            rd_chk(IDX_BAL_CTRL, 32'(m));
            for (int i = 0; i < 5; i++) begin
                wr(exp_idx(i), 32'(m * 16 + i + 1));
                if (i != 0 && m < 4) exp_r[i] = 10'(m * 16 + i + 1);
            end
            wr(IDX_BAL_CTRL, 32'h0);
            for (int i = 0; i < 5; i++) rd_chk(exp_idx(i), {22'h0, exp_r[i]});
        end
        wr(8'h60, 32'hffffffff);
        rd_chk(8'h60, 32'h0);
        rd_chk(IDX_EXP_MASTER, {22'h0, exp_r[0]});
        wr(IDX_EXP_MASTER, 32'h3);
        wr(IDX_EXP_CELL_TWO, 32'h3ff);
        wr(IDX_EXP_CELL_THREE, 32'h0);
        wr(IDX_EXP_CELL_FOUR, 32'h2);
        wr(IDX_EXP_CELL_FIVE, 32'h3ff);
        wr(IDX_BAL_CTRL, 32'(CBE_GROUP_SEC));
        repeat (3) @(posedge hclk);
        `CHK(allow, 5'h1f)
        repeat (11) @(posedge hclk);
        `CHK(timer, 10'h001)
        repeat (30) @(posedge hclk);
        `CHK(allow, 5'h00)
        wr(IDX_BAL_CTRL, 32'h0);
        wr(IDX_EXP_MASTER, 32'h3ff);
        wr(IDX_BAL_CTRL, 32'(CBE_GROUP_SEC));
        repeat (50) @(posedge hclk);
        `CHK(allow, 5'h1f)
        wr(IDX_BAL_CTRL, 32'h0);
        wr(IDX_EXP_MASTER, 32'h0);
        wr(IDX_BAL_CTRL, 32'(CBE_GROUP_MIN));
        repeat (3) @(posedge hclk);
        `CHK(allow, 5'h00)
        wr(IDX_BAL_CTRL, 32'h0);
        wr(IDX_EXP_MASTER, 32'h3ff);
        wr(IDX_BAL_CTRL, 32'(CBE_INDIV_SEC));
        repeat (3) @(posedge hclk);
        `CHK(allow, 5'b11011)
        repeat (40) @(posedge hclk);
        `CHK(allow, 5'b10011)
        wr(IDX_BAL_CTRL, 32'h0);
        wr(IDX_EXP_MASTER, 32'h3);
        wr(IDX_BAL_CTRL, 32'(CBE_MANUAL_SEC));
        repeat (22) @(posedge hclk);
        `CHK(timer, 10'h002)
        wr(IDX_BAL_CTRL, 32'h101);
        @(posedge hclk);
        `CHK(timer, 10'h000)
        // status: timer still zero after restart, all switches allowed
        rd_chk(IDX_BAL_STATUS, 32'h001f_0000);
        repeat (50) @(posedge hclk);
        `CHK(allow, 5'h00)
        wr(IDX_BAL_CTRL, 32'h101);
        @(posedge hclk);
        `CHK(timer == 10'h000, 1'b0)
        wr(IDX_BAL_CTRL, 32'h0);
        wr(IDX_EXP_MASTER, 32'h2);
        wr(IDX_BAL_CTRL, 32'(CBE_DISCH_MIN));
        repeat (300) @(posedge hclk);
        `CHK(timer, 10'h000)
        repeat (400) @(posedge hclk);
        `CHK(timer, 10'h001)
        finish_test();
    end
endmodule
